// ==== rtl/fcs_pkg.sv ====
// Package with register map, command codes and timing for the flash command sequencer.
package fcs_pkg;
  // Bus address width, array geometry, divider and timer widths.
  localparam int ADDR_W = 16;
  localparam int ARR_AW = 13;
  localparam int PAGE_LSB = 9;
  localparam int DIV_W = 6;
  localparam int TK_W = 15;

  // Register byte addresses; the array write window decodes on the top three bits.
  localparam logic [15:0] OFS_DIV = 16'h0000;
  localparam logic [15:0] OFS_STAT = 16'h0004;
  localparam logic [15:0] OFS_CMD = 16'h0008;
  localparam logic [2:0] ARR_SEL = 3'h1;

  // Status bit positions.
  localparam int ST_CBEF = 7;
  localparam int ST_CCF = 6;
  localparam int ST_ACCERR = 4;
  localparam int ST_BLANK = 2;
  // Divider register: bit 7 reads back as the written-once flag.
  localparam int DV_DONE = 7;

  // Command codes.
  localparam logic [7:0] CMD_BLANK = 8'h05;
  localparam logic [7:0] CMD_BYTE = 8'h20;
  localparam logic [7:0] CMD_BURST = 8'h25;
  localparam logic [7:0] CMD_PAGE = 8'h40;
  localparam logic [7:0] CMD_MASS = 8'h41;

  // Operation lengths in timing-clock periods.
  localparam logic [14:0] TK_BYTE = 15'h0009;
  localparam logic [14:0] TK_BURST = 15'h0004;
  localparam logic [14:0] TK_PAGE = 15'h0fa0;
  localparam logic [14:0] TK_MASS = 15'h4e20;
  localparam logic [14:0] TK_BLANK = 15'h0010;
  localparam logic [14:0] TK_ONE = 15'h0001;

  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Command sequence state.
  typedef enum logic [1:0] {
    SQ_IDLE = 2'b00,
    SQ_ADDR = 2'b01,
    SQ_CMD = 2'b10,
    SQ_BUSY = 2'b11
  } fcs_seq_t;

  // Latched array write plus buffered command.
  typedef struct packed {
    logic [12:0] addr;
    logic [7:0] data;
    logic [7:0] cmd;
  } fcs_req_t;
endpackage

// ==== rtl/fcs_top.sv ====
// Flash command sequencer with AXI4-Lite register access.
//
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
// Operation
// RULE1: Software sets the divider so the timing clock is 150 to 200 kHz.
// RULE2: Divider register takes only its first write after reset.
// RULE3: Divider writes are refused while the access error flag is set.
// RULE4: Operations are timed in whole periods of the divided timing clock.
// RULE5: Byte program takes 9 periods, each burst byte 4 periods.
// RULE6: Page erase takes 4000 periods, mass erase 20000 periods.
// RULE7: Each sequence starts with an array write whose address and data are latched.
// RULE8: Page erase uses the page of the address; other data is ignored.
// RULE9: Command write is buffered; 0x05 blank, 0x20 byte, 0x25 burst.
// RULE10: Code 0x40 erases one page, 0x41 erases the whole array.
// RULE11: Any other command code sets the access error flag.
// RULE12: Writing one to the buffer-empty flag launches the buffered command.
// RULE13: Writing zero to it mid-sequence aborts and sets the access error.
// RULE14: Software clears error flags before starting a new sequence.
// RULE15: A complete flag rises when the launched operation finishes.
// RULE16: Sequence violations set status bit 4 and discard the command.
// RULE17: Program or erase before the divider is written is an access error.
// RULE18: Stop mode entry during an operation sets the access error.
// RULE19: Access error clears only on a written one.
// RULE20: Blank check sets status bit 2 when the array reads all 0xff.
// RULE21: Blank flag clears on a valid launch; direct writes do nothing.
// RULE22: Software never programs a byte twice without erasing first.
// RULE23: Complete flag drops at launch and rises after the operation ends.
module fcs_top
  import fcs_pkg::*;
(
  // Clock and reset.
  input wire logic I_CLK,
  input wire logic I_RESET_N,
  // AXI4-Lite write address and data.
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [15:0] I_AWADDR,
  input wire logic I_WVALID,
  output logic O_WREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  // AXI4-Lite write response.
  output logic O_BVALID,
  input wire logic I_BREADY,
  output logic [1:0] O_BRESP,
  // AXI4-Lite read.
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  input wire logic [15:0] I_ARADDR,
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  // System and array side.
  input wire logic I_STOP,
  input wire logic I_ARR_ERASED,
  output logic [12:0] O_ARR_ADDR,
  output logic [7:0] O_ARR_DATA,
  output logic O_ARR_PROG,
  output logic O_ARR_PAGE_ERASE,
  output logic O_ARR_MASS_ERASE,
  output logic O_ARR_BLANK_CHK
);

  // Length of an operation in timing periods for a given command.
  function automatic logic [14:0] op_len(input logic [7:0] c);
    logic [14:0] n;
    n = TK_BLANK;
    if (c == CMD_BYTE) begin
      n = TK_BYTE;
    end else if (c == CMD_BURST) begin
      n = TK_BURST;
    end else if (c == CMD_PAGE) begin
      n = TK_PAGE;
    end else if (c == CMD_MASS) begin
      n = TK_MASS;
    end
    return n;
  endfunction

  // True for one of the five recognised codes.
  function automatic logic cmd_ok(input logic [7:0] c);
    return (c == CMD_BLANK) || (c == CMD_BYTE) || (c == CMD_BURST) ||
           (c == CMD_PAGE) || (c == CMD_MASS);
  endfunction

  // True when an address falls in the array write window.
  function automatic logic is_arr(input logic [15:0] a);
    return a[15:13] == ARR_SEL;
  endfunction

  // True for any mapped address.
  function automatic logic is_mapped(input logic [15:0] a);
    return (a == OFS_DIV) || (a == OFS_STAT) || (a == OFS_CMD) || is_arr(a);
  endfunction

  logic aw_hold_reg;
  logic [15:0] aw_addr_reg;
  logic w_hold_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic wr_fire;
  logic wr_lane;
  logic wr_div, wr_stat, wr_cmd, wr_arr;
  logic [5:0] div_val_reg;
  logic div_done_reg;
  logic [5:0] div_cnt_reg;
  logic tick;
  fcs_seq_t seq_reg;
  fcs_req_t req_reg;
  logic [14:0] op_cnt_reg;
  logic [14:0] op_len_reg;
  logic op_done;
  logic launch_go;
  logic seq_err;
  logic stop_reg;
  logic stop_err;
  logic accerr_reg, ccf_reg, blank_reg;
  logic [7:0] status;

  // Bus handshakes; the address and data channels are caught independently.
  assign O_AWREADY = ~aw_hold_reg;
  assign O_WREADY = ~w_hold_reg;
  assign O_BVALID = bvalid_reg;
  assign O_BRESP = bresp_reg;
  assign O_ARREADY = ~rvalid_reg;
  assign O_RVALID = rvalid_reg;
  assign O_RDATA = rdata_reg;
  assign O_RRESP = rresp_reg;

  // A write acts once both halves are held and the last response is gone.
  assign wr_fire = aw_hold_reg & w_hold_reg & ~bvalid_reg;
  assign wr_lane = wr_fire & w_strb_reg[0];
  assign wr_div = wr_lane & (aw_addr_reg == OFS_DIV);
  assign wr_stat = wr_lane & (aw_addr_reg == OFS_STAT);
  assign wr_cmd = wr_lane & (aw_addr_reg == OFS_CMD);
  assign wr_arr = wr_lane & is_arr(aw_addr_reg);

  // Write address channel.
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (I_AWVALID && !aw_hold_reg) begin
      aw_hold_reg <= 1'b1;
      aw_addr_reg <= I_AWADDR;
    end else if (wr_fire) begin
      aw_hold_reg <= 1'b0;
    end
  end

  // Write data channel.
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      w_hold_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else if (I_WVALID && !w_hold_reg) begin
      w_hold_reg <= 1'b1;
      w_data_reg <= I_WDATA;
      w_strb_reg <= I_WSTRB;
    end else if (wr_fire) begin
      w_hold_reg <= 1'b0;
    end
  end

  // Write response; unmapped addresses answer with a slave error.
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= is_mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
    end else if (I_BREADY) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Read channel; the array window reads as zero since reads go elsewhere.
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else if (I_ARVALID && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= is_mapped(I_ARADDR) ? RESP_OKAY : RESP_SLVERR;
      if (I_ARADDR == OFS_DIV) begin
        rdata_reg <= {24'h000000, div_done_reg, 1'b0, div_val_reg};
      end else if (I_ARADDR == OFS_STAT) begin
        rdata_reg <= {24'h000000, status};
      end else if (I_ARADDR == OFS_CMD) begin
        rdata_reg <= {24'h000000, req_reg.cmd};
      end else begin
        rdata_reg <= '0;
      end
    end else if (I_RREADY) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Divider register, written once after reset.
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      div_val_reg <= '0;
      div_done_reg <= 1'b0;
    // RULE2 RULE3 one-time gated write
    end else if (wr_div && !div_done_reg && !accerr_reg) begin
      div_val_reg <= w_data_reg[DIV_W-1:0];
      div_done_reg <= 1'b1;
    end
  end

  // Enable every div_val + 1 cycles; unwritten, it pulses each cycle so blank check ends.
  // RULE4 timing clock enable
  assign tick = div_cnt_reg == div_val_reg;
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      div_cnt_reg <= '0;
    end else if (!div_done_reg || tick) begin
      div_cnt_reg <= '0;
    end else begin
      div_cnt_reg <= div_cnt_reg + 6'h01;
    end
  end

  // Launch decision for a one written to the buffer-empty bit.
  // RULE17 divider before program
  assign launch_go = wr_stat && w_data_reg[ST_CBEF] && (seq_reg == SQ_CMD) &&
                     (div_done_reg || (req_reg.cmd == CMD_BLANK));

  // Every way the sequence can be broken; status writes count only while not busy.
  always_comb begin
    seq_err = 1'b0;
    // RULE16 sequence violations
    if (wr_arr && !accerr_reg && (seq_reg != SQ_IDLE)) begin
      seq_err = 1'b1;
    end else if (wr_cmd && (seq_reg != SQ_ADDR)) begin
      seq_err = 1'b1;
    // RULE11 illegal code
    end else if (wr_cmd && !cmd_ok(w_data_reg[7:0])) begin
      seq_err = 1'b1;
    end else if (wr_stat && (seq_reg != SQ_BUSY)) begin
      // RULE13 abort by zero
      if (!w_data_reg[ST_CBEF] && (seq_reg != SQ_IDLE)) begin
        seq_err = 1'b1;
      // RULE17 launch refused
      end else if (w_data_reg[ST_CBEF] && (seq_reg != SQ_IDLE) && !launch_go) begin
        seq_err = 1'b1;
      end
    end
  end

  // Stop entry is caught on its rising level while an operation runs.
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      stop_reg <= 1'b0;
    end else begin
      stop_reg <= I_STOP;
    end
  end
  // RULE18 stop during operation
  assign stop_err = I_STOP && !stop_reg && (seq_reg == SQ_BUSY);

  // RULE5 RULE6 operation length
  assign op_done = tick && (seq_reg == SQ_BUSY) && (op_cnt_reg + TK_ONE == op_len_reg);

  // Command sequence state machine.
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      seq_reg <= SQ_IDLE;
    end else begin
      case (seq_reg)
        SQ_IDLE: begin
          // RULE7 array write first
          if (wr_arr && !accerr_reg) begin
            seq_reg <= SQ_ADDR;
          end
        end
        SQ_ADDR: begin
          if (seq_err) begin
            seq_reg <= SQ_IDLE;
          end else if (wr_cmd) begin
            seq_reg <= SQ_CMD;
          end
        end
        SQ_CMD: begin
          // RULE12 launch
          if (launch_go) begin
            seq_reg <= SQ_BUSY;
          end else if (seq_err) begin
            seq_reg <= SQ_IDLE;
          end
        end
        SQ_BUSY: begin
          if (op_done || stop_err) begin
            seq_reg <= SQ_IDLE;
          end
        end
        default: begin
          seq_reg <= SQ_IDLE;
        end
      endcase
    end
  end

  // Latched address, data and buffered command.
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      req_reg <= '0;
    // RULE7 latch address and data
    end else if (wr_arr && !accerr_reg && (seq_reg == SQ_IDLE)) begin
      req_reg.addr <= aw_addr_reg[ARR_AW-1:0];
      req_reg.data <= w_data_reg[7:0];
    // RULE9 command buffer
    end else if (wr_cmd && (seq_reg == SQ_ADDR) && cmd_ok(w_data_reg[7:0])) begin
      req_reg.cmd <= w_data_reg[7:0];
    end
  end

  // Operation timer counting timing periods.
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      op_cnt_reg <= '0;
      op_len_reg <= '0;
    end else if (launch_go) begin
      op_cnt_reg <= '0;
      op_len_reg <= op_len(req_reg.cmd);
    end else if ((seq_reg == SQ_BUSY) && tick) begin
      op_cnt_reg <= op_cnt_reg + TK_ONE;
    end
  end

  // High-voltage and check enables toward the array, held for the operation.
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_ARR_PROG <= 1'b0;
      O_ARR_PAGE_ERASE <= 1'b0;
      O_ARR_MASS_ERASE <= 1'b0;
      O_ARR_BLANK_CHK <= 1'b0;
    end else if (launch_go) begin
      O_ARR_PROG <= (req_reg.cmd == CMD_BYTE) || (req_reg.cmd == CMD_BURST);
      // RULE10 page and mass erase
      O_ARR_PAGE_ERASE <= req_reg.cmd == CMD_PAGE;
      O_ARR_MASS_ERASE <= req_reg.cmd == CMD_MASS;
      O_ARR_BLANK_CHK <= req_reg.cmd == CMD_BLANK;
    end else if (op_done || stop_err) begin
      O_ARR_PROG <= 1'b0;
      O_ARR_PAGE_ERASE <= 1'b0;
      O_ARR_MASS_ERASE <= 1'b0;
      O_ARR_BLANK_CHK <= 1'b0;
    end
  end

  // Page erase drops the in-page offset so any address picks the page.
  // RULE8 page select
  assign O_ARR_ADDR = (req_reg.cmd == CMD_PAGE) ?
                      {req_reg.addr[ARR_AW-1:PAGE_LSB], {PAGE_LSB{1'b0}}} : req_reg.addr;
  assign O_ARR_DATA = req_reg.data;

  // Access error: a new event wins over a clear in the same cycle.
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      accerr_reg <= 1'b0;
    // RULE16 RULE18 set on error
    end else if (seq_err || stop_err) begin
      accerr_reg <= 1'b1;
    // RULE19 clear by one
    end else if (wr_stat && w_data_reg[ST_ACCERR]) begin
      accerr_reg <= 1'b0;
    end
  end

  // Complete flag: low from launch until the timer runs out or a stop aborts.
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      ccf_reg <= 1'b1;
    // RULE23 clear at launch
    end else if (launch_go) begin
      ccf_reg <= 1'b0;
    // RULE15 set at end
    end else if (op_done || stop_err) begin
      ccf_reg <= 1'b1;
    end
  end

  // Blank result; writes from software never reach it.
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      blank_reg <= 1'b0;
    // RULE21 clear on launch
    end else if (launch_go) begin
      blank_reg <= 1'b0;
    // RULE20 blank result
    end else if (op_done && O_ARR_BLANK_CHK) begin
      blank_reg <= I_ARR_ERASED;
    end
  end

  // Status byte; buffer-empty reads high whenever no sequence is open.
  always_comb begin
    status = 8'h00;
    status[ST_CBEF] = seq_reg == SQ_IDLE;
    status[ST_CCF] = ccf_reg;
    status[ST_ACCERR] = accerr_reg;
    status[ST_BLANK] = blank_reg;
  end

endmodule // fcs_top

// ==== verification/fcs_chk.sv ====
// Port-level checker for the flash command sequencer.
`timescale 1ns/1ns
module fcs_chk
  import fcs_pkg::*;
(
  // Clock, reset, bus and stop inputs.
  input wire logic I_CLK,
  input wire logic I_RESET_N,
  input wire logic I_BREADY,
  input wire logic I_RREADY,
  input wire logic I_STOP,
  // Design outputs under watch.
  input wire logic O_ARREADY,
  input wire logic O_BVALID,
  input wire logic [1:0] O_BRESP,
  input wire logic O_RVALID,
  input wire logic [31:0] O_RDATA,
  input wire logic [12:0] O_ARR_ADDR,
  input wire logic O_ARR_PROG,
  input wire logic O_ARR_PAGE_ERASE,
  input wire logic O_ARR_MASS_ERASE,
  input wire logic O_ARR_BLANK_CHK
);
  logic [3:0] en;

  // All array operation enables gathered in one vector.
  assign en = {O_ARR_PROG, O_ARR_PAGE_ERASE, O_ARR_MASS_ERASE, O_ARR_BLANK_CHK};

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RESET_N);

  // Bus answers must hold until the master takes them; upper read bits are zero and read ready is the inverse of read valid.
  chk_bresp_hold: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
    else $error("write response dropped early");
  chk_rdata_hold: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
    else $error("read data dropped early");
  chk_rdata_upper: assert property (O_RVALID |-> O_RDATA[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  chk_ar_ready: assert property (O_ARREADY != O_RVALID)
    else $error("read address ready wrong");
  // Array side: one operation at a time, latched target kept steady, page erase page aligned, stop ends the operation.
  chk_one_op: assert property ($onehot0(en))
    else $error("more than one array operation");
  chk_addr_latch: assert property (en != 4'h0 && $past(en) != 4'h0 |-> $stable(O_ARR_ADDR))
    else $error("array address moved during operation");
  chk_page_align: assert property (O_ARR_PAGE_ERASE |-> O_ARR_ADDR[8:0] == 9'h0)
    else $error("page erase address not page aligned");
  chk_stop_abort: assert property ($rose(I_STOP) && en != 4'h0 |-> ##[1:3] en == 4'h0)
    else $error("operation kept running after stop");

  // Main scenarios reached.
  cover property ($fell(O_ARR_MASS_ERASE));
  cover property ($rose(O_ARR_BLANK_CHK));
  cover property (O_BVALID && O_BRESP == RESP_SLVERR);
endmodule // fcs_chk

// ==== verification/tb_top.sv ====
// Self-checking testbench for the flash command sequencer.
`timescale 1ns/1ns
module tb_top
  import fcs_pkg::*;
;
  logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, stop, erased;
  logic awready, wready, bvalid, arready, rvalid;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [1:0] bresp, rresp, lresp;
  logic [12:0] arr_addr;
  logic [7:0] arr_data;
  logic [3:0] en, mask;
  int n_errors, num_checks, en_cnt, c0;
  logic [7:0] cmds [6] = '{CMD_BLANK, CMD_BYTE, CMD_BURST, CMD_PAGE, CMD_MASS, CMD_BLANK};
  int ticks [6] = '{TK_BLANK, TK_BYTE, TK_BURST, TK_PAGE, TK_MASS, TK_BLANK};
  logic [3:0] masks [6] = '{4'h1, 4'h8, 4'h8, 4'h4, 4'h2, 4'h1};

  fcs_top u_dut (
    .I_CLK(clk), .I_RESET_N(rst_n),
    .I_AWVALID(awvalid), .O_AWREADY(awready), .I_AWADDR(awaddr),
    .I_WVALID(wvalid), .O_WREADY(wready), .I_WDATA(wdata), .I_WSTRB(4'h1),
    .O_BVALID(bvalid), .I_BREADY(bready), .O_BRESP(bresp),
    .I_ARVALID(arvalid), .O_ARREADY(arready), .I_ARADDR(araddr),
    .O_RVALID(rvalid), .I_RREADY(rready), .O_RDATA(rdata), .O_RRESP(rresp),
    .I_STOP(stop), .I_ARR_ERASED(erased),
    .O_ARR_ADDR(arr_addr), .O_ARR_DATA(arr_data),
    .O_ARR_PROG(en[3]), .O_ARR_PAGE_ERASE(en[2]),
    .O_ARR_MASS_ERASE(en[1]), .O_ARR_BLANK_CHK(en[0])
  );

  // Free running bus clock.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Counts cycles in which the selected operation runs; sampled before the edge lands.
  always @(posedge clk) begin
    if ((en & mask) != 4'h0) en_cnt <= en_cnt + 1;
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Ready is sampled at the falling edge, where it is settled, and acted on at the next rise.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic ha, hw, hb;
    int t;
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= {24'h0, d};
    bready <= 1'b1;
    hb = 1'b0;
    for (t = 0; t < 200 && !hb; t++) begin
      @(negedge clk);
      ha = awready & awvalid;
      hw = wready & wvalid;
      hb = bvalid;
      lresp = bresp;
      @(posedge clk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk("bvalid", {31'h0, hb}, 32'h1);
  endtask

  task automatic rd(input logic [15:0] a, output logic [31:0] x);
    logic ha, hr;
    int t;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    hr = 1'b0;
    for (t = 0; t < 200 && !hr; t++) begin
      @(negedge clk);
      ha = arready & arvalid;
      hr = rvalid;
      x = rdata;
      lresp = rresp;
      @(posedge clk);
      if (ha) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    chk("rvalid", {31'h0, hr}, 32'h1);
  endtask

  task automatic rc(input string nm, input logic [15:0] a, input logic [31:0] e);
    logic [31:0] x;
    rd(a, x);
    chk(nm, x, e);
  endtask

  // Full sequence: array write, command, launch.
  task automatic run(input logic [15:0] a, input logic [7:0] c);
    wr(a, 8'h5a);
    wr(OFS_CMD, c);
    wr(OFS_STAT, 8'h80);
  endtask

  // A refused sequence shows the error flag and never starts the array.
  task automatic ok_err(input string nm);
    rc(nm, OFS_STAT, 32'hd0);
    chk(nm, en_cnt, c0);
  endtask

  // Error flags are cleared before any new sequence.
  task automatic clr();
    wr(OFS_STAT, 8'h10);
    rc("clear", OFS_STAT, 32'hc0);
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Cuts a hang short; the tests need about half this span.
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    close_out();
  end

  // Main sequence. A short divider makes one tick two bus cycles so the erases fit the run.
  // The in-range divider of the timing clock is exercised after the second reset.
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, stop, erased} = 7'h0;
    awaddr = 16'h0;
    araddr = 16'h0;
    wdata = 32'h0;
    mask = 4'hf;
    rst_n = 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rc("stat_rst", OFS_STAT, 32'hc0);
    rc("div_rst", OFS_DIV, 32'h0);
    c0 = en_cnt;
    run(16'h2010, CMD_BYTE);
    ok_err("no_div");
    wr(OFS_DIV, 8'h01);
    rc("div_locked", OFS_DIV, 32'h0);
    wr(OFS_STAT, 8'h00);
    rc("err_hold", OFS_STAT, 32'hd0);
    clr();
    wr(OFS_DIV, 8'h01);
    wr(OFS_DIV, 8'h05);
    rc("div_once", OFS_DIV, 32'h81);
    $display("test divider done");
    for (int k = 0; k < 6; k++) begin
      mask <= masks[k];
      erased <= (k == 0);
      c0 = en_cnt;
      run(k == 2 ? 16'h2324 : 16'h2323, cmds[k]);
      if (k == 1) chk("addr", {19'h0, arr_addr}, 32'h323);
      if (k == 1) chk("data", {24'h0, arr_data}, 32'h5a);
      if (k == 3) chk("page", {19'h0, arr_addr}, 32'h200);
      if (k > 2) rd(OFS_STAT, v);
      if (k > 2) chk("ccf_low", v & 32'h40, 32'h0);
      for (int t = 0; t < 50000 && en != 4'h0; t++) @(negedge clk);
      v = en_cnt - c0;
      chk("length", 32'(v >= 2 * ticks[k] - 1 && v <= 2 * ticks[k]), 32'h1);
      rc("done", OFS_STAT, k == 0 ? 32'hc4 : 32'hc0);
      if (k == 0) wr(OFS_STAT, 8'h00);
      if (k == 0) rc("blank_ro", OFS_STAT, 32'hc4);
    end
    $display("test commands done");
    mask <= 4'hf;
    c0 = en_cnt;
    run(16'h2000, 8'h33);
    ok_err("illegal");
    clr();
    wr(16'h2000, 8'h00);
    wr(OFS_STAT, 8'h00);
    ok_err("abort");
    clr();
    wr(OFS_CMD, CMD_BYTE);
    ok_err("order");
    clr();
    $display("test errors done");
    run(16'h2000, CMD_MASS);
    stop <= 1'b1;
    repeat (4) @(negedge clk);
    chk("stop_en", {28'h0, en}, 32'h0);
    rc("stop_stat", OFS_STAT, 32'hd0);
    stop <= 1'b0;
    clr();
    $display("test stop done");
    rd(16'h0100, v);
    chk("rresp", {30'h0, lresp}, {30'h0, RESP_SLVERR});
    wr(16'h0100, 8'h01);
    chk("bresp", {30'h0, lresp}, {30'h0, RESP_SLVERR});
    $display("test unmapped done");
    // A second reset frees the divider, so an in-range divider can time a byte program.
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rc("stat_rst2", OFS_STAT, 32'hc0);
    rc("div_rst2", OFS_DIV, 32'h0);
    mask <= 4'h1;
    erased <= 1'b1;
    c0 = en_cnt;
    run(16'h2000, CMD_BLANK);
    for (int t = 0; t < 50000 && en != 4'h0; t++) @(negedge clk);
    chk("blank_nodiv", en_cnt - c0, ticks[0]);
    rc("blank_nodiv_st", OFS_STAT, 32'hc4);
    wr(OFS_DIV, 8'h31);
    rc("div_slow", OFS_DIV, 32'hb1);
    mask <= 4'h8;
    erased <= 1'b0;
    c0 = en_cnt;
    run(16'h2040, CMD_BYTE);
    for (int t = 0; t < 50000 && en != 4'h0; t++) @(negedge clk);
    v = en_cnt - c0;
    chk("slow_len", 32'(v >= 50 * ticks[1] - 49 && v <= 50 * ticks[1]), 32'h1);
    rc("slow_done", OFS_STAT, 32'hc0);
    $display("test second reset done");
    close_out();
  end
endmodule // tb_top

bind fcs_top fcs_chk u_chk (
  .I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_BREADY(I_BREADY), .I_RREADY(I_RREADY),
  .I_STOP(I_STOP), .O_ARREADY(O_ARREADY), .O_BVALID(O_BVALID), .O_BRESP(O_BRESP),
  .O_RVALID(O_RVALID), .O_RDATA(O_RDATA), .O_ARR_ADDR(O_ARR_ADDR),
  .O_ARR_PROG(O_ARR_PROG), .O_ARR_PAGE_ERASE(O_ARR_PAGE_ERASE),
  .O_ARR_MASS_ERASE(O_ARR_MASS_ERASE), .O_ARR_BLANK_CHK(O_ARR_BLANK_CHK)
);
